/* File: include/srp_cfg.svh */
// srp_cfg.svh: numeric constants of the serial register and waveform table port
// assumes inclusion by bare name from the package and the design modules
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH
// frame layout
`define SRP_FRAME_BITS 40
`define SRP_CNT_W 6
`define SRP_WR_BIT 39
`define SRP_ADDR_HI 38
`define SRP_ADDR_LO 32
`define SRP_HDR_LO 32
`define SRP_DATA_HI 31
`define SRP_DATA_W 32
// register addresses, 7 bits
`define SRP_A_CFG 7'h00
`define SRP_A_EVENT 7'h02
`define SRP_A_MASK 7'h03
`define SRP_A_ERRCNT 7'h04
`define SRP_A_TBL_WR 7'h05
`define SRP_A_TBL_RD 7'h06
`define SRP_A_VERSION 7'h07
// waveform table geometry and write field positions
`define SRP_TBL_DEPTH 8192
`define SRP_TBL_AW 13
`define SRP_TBL_DW 12
`define SRP_TBL_IDX_HI 28
`define SRP_TBL_IDX_LO 16
`define SRP_TBL_VAL_HI 11
// event and reset values
`define SRP_EV_W 8
`define SRP_CFG_RST 32'h0000_0000
`define SRP_MASK_RST 8'h00
`define SRP_VERSION_DEF 32'h0a5c_0001
`endif

/* File: include/srp_pkg.sv */
// srp_pkg: shared types of the serial register and waveform table port
// assumes srp_cfg.svh on the include path
`include "srp_cfg.svh"
package srp_pkg;
    typedef logic [`SRP_FRAME_BITS-1:0] srp_frame_t;  // one whole datagram
    typedef logic [`SRP_ADDR_HI-`SRP_ADDR_LO:0] srp_addr_t;  // register number
    typedef logic [`SRP_DATA_W-1:0] srp_word_t;  // right aligned data
    typedef logic [`SRP_TBL_AW-1:0] srp_tidx_t;  // table index
    typedef logic [`SRP_TBL_DW-1:0] srp_tval_t;  // table entry
    // frame end judgement in the core domain
    typedef enum logic [2:0] {
        SRP_IDLE = 3'b001,
        SRP_BUSY = 3'b010,
        SRP_DONE = 3'b100
    } srp_frm_t;
endpackage

/* File: rtl/srp_link.sv */
// srp_link: serial shift logic running on the host's serial clock
// assumes the host clocks only while chip select is low, data sampled on rising edges
`timescale 1ns/10ps
`include "srp_cfg.svh"
module srp_link
    import srp_pkg::*;
(
    // serial pins
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // towards the core domain
    input wire srp_frame_t resp_in,
    output srp_frame_t frame_out,
    output logic done_out,
    output logic long_out
);
    localparam logic [`SRP_CNT_W-1:0] LAST = `SRP_CNT_W'(`SRP_FRAME_BITS - 1);
    localparam logic [`SRP_CNT_W-1:0] OVER = `SRP_CNT_W'(`SRP_FRAME_BITS);

    logic [`SRP_CNT_W-1:0] cnt_q;  // bits taken this frame
    srp_frame_t sh_q;  // incoming shift register
    srp_frame_t frame_q;  // last complete frame
    logic done_q;  // at least 40 bits seen so far
    logic long_q;  // more than 40 bits seen

    // bit counter, cleared while chip select is high; saturates past the end
    always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            cnt_q <= '0;
        end else if (cnt_q <= OVER) begin
            cnt_q <= cnt_q + `SRP_CNT_W'(1);
        end
    end

    // msb first shifting
    always_ff @(posedge spi_sclk_in) begin
        sh_q <= {sh_q[`SRP_FRAME_BITS-2:0], spi_mosi_in};
    end

    // capture the word on the fortieth bit
    always_ff @(posedge spi_sclk_in) begin
        if (cnt_q == LAST) begin
            frame_q <= {sh_q[`SRP_FRAME_BITS-2:0], spi_mosi_in};
        end
    end

    // frame length flags; they stand after release so the core can judge them,
    // and the first clock edge of the next frame clears them
    always_ff @(posedge spi_sclk_in) begin
        if (cnt_q == LAST) begin
            done_q <= 1'b1;
        end else if (cnt_q == '0) begin
            done_q <= 1'b0;
        end
        if (cnt_q >= OVER) begin
            long_q <= 1'b1;
        end else if (cnt_q == '0) begin
            long_q <= 1'b0;
        end
    end

    // reply bit chosen by the counter, msb first; zero past the end
    assign spi_miso_out = (cnt_q <= LAST) ? resp_in[LAST - cnt_q] : 1'b0;
    assign spi_miso_oe_out = ~spi_cs_n_in;
    assign frame_out = frame_q;
    assign done_out = done_q;
    assign long_out = long_q;
endmodule

/* File: rtl/srp_sync.sv */
// srp_sync: three-stage synchroniser for levels entering the core clock
// assumes inputs are levels that stay stable for several core cycles
`timescale 1ns/10ps
module srp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;  // first stage, read only by s2
    logic [WIDTH-1:0] s2_q;  // second stage
    logic [WIDTH-1:0] s3_q;  // third stage
    logic [WIDTH-1:0] out_q;  // accepted level

    // shift chain
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit changes only when stage two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            out_q <= INIT;
        end else begin
            out_q <= (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
        end
    end

    assign sync_out = out_q;
endmodule

/* File: rtl/srp_top.sv */
// srp_top: serial register port with waveform table, event flags and interrupt pin
// assumes a host holding chip select high for at least 6 core cycles between frames
//
// Notes on behaviour
// - a valid access is exactly forty bits
// - address byte then four data bytes
// - all 32 data bits always move
// - bit 39 high writes, low reads
// - data bits of a read are ignored
// - values right aligned in the word
// - table holds 8192 twelve-bit entries
// - separate addresses write and read the table
// - table read data arrives one frame later
// - event register clears itself when read
// - error count clears on a write to its own address
// - configuration only through register writes
// - unmasked pending event pulls interrupt low
`timescale 1ns/10ps
`include "srp_cfg.svh"
module srp_top
    import srp_pkg::*;
#(
    parameter int TBL_DEPTH = `SRP_TBL_DEPTH,
    parameter srp_word_t VERSION = `SRP_VERSION_DEF  // arbitrary identification value
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // serial link from the host
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // open-drain interrupt pin
    output logic irq_out_n,
    output logic irq_oe_out,
    // motion core side
    input wire logic [`SRP_EV_W-1:0] event_in,
    output srp_word_t cfg_out,
    input wire srp_tidx_t seq_idx_in,
    output srp_tval_t seq_val_out
);
    // frame fields
    function automatic srp_addr_t f_addr(input srp_frame_t f);
        f_addr = f[`SRP_ADDR_HI:`SRP_ADDR_LO];
    endfunction

    function automatic srp_word_t f_data(input srp_frame_t f);
        f_data = f[`SRP_DATA_HI:0];
    endfunction

    // link side signals
    srp_frame_t frame;  // captured frame from the link domain
    logic done_raw;  // forty bits seen, link domain
    logic long_raw;  // overlong frame, link domain
    logic cs_n_s;  // chip select in the core domain
    logic done_s;  // forty bits seen, core domain
    logic long_s;  // overlong, core domain
    srp_frame_t resp_q;  // reply shifted out in the next frame

    // core state
    srp_frm_t frm_q;  // frame tracking state
    logic ok_q;  // length flags seen clear inside this frame
    logic commit;  // one-cycle accepted frame
    logic bad;  // one-cycle rejected frame
    logic wr;  // write direction of the frame
    srp_addr_t addr;  // register addressed
    srp_word_t wdata;  // data of the frame
    srp_word_t cfg_q;  // configuration word
    logic [`SRP_EV_W-1:0] ev_q;  // sticky events
    logic [`SRP_EV_W-1:0] mask_q;  // interrupt mask
    srp_word_t errcnt_q;  // rejected frame count
    srp_tidx_t tptr_q;  // table read pointer
    srp_tval_t trd_q;  // pending table read data
    srp_tval_t seq_q;  // table value for the sequencer
    logic irq_q;  // interrupt drive
    logic ev_clr;  // read of the event register
    logic err_clr;  // write to the error count
    srp_word_t rdata;  // value for a read

    // table storage, not preset
    srp_tval_t table_mem [TBL_DEPTH];

    // link domain logic
    srp_link u_link (
        .spi_sclk_in(spi_sclk_in),
        .spi_cs_n_in(spi_cs_n_in),
        .spi_mosi_in(spi_mosi_in),
        .spi_miso_out(spi_miso_out),
        .spi_miso_oe_out(spi_miso_oe_out),
        .resp_in(resp_q),
        .frame_out(frame),
        .done_out(done_raw),
        .long_out(long_raw)
    );

    // bring chip select and length flags into the core clock
    srp_sync #(
        .WIDTH(3),
        .INIT(3'b100)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .async_in({spi_cs_n_in, done_raw, long_raw}),
        .sync_out({cs_n_s, done_s, long_s})
    );

    // frame tracking: busy while selected, done for one cycle at release
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            frm_q <= SRP_IDLE;
        end else begin
            unique case (frm_q)
                SRP_IDLE: begin
                    if (!cs_n_s) begin
                        frm_q <= SRP_BUSY;
                    end
                end
                SRP_BUSY: begin
                    if (cs_n_s) begin
                        frm_q <= SRP_DONE;
                    end
                end
                SRP_DONE: begin
                    frm_q <= cs_n_s ? SRP_IDLE : SRP_BUSY;
                end
            endcase
        end
    end

    // flags must be seen clear inside the frame, so a frame without clock
    // edges cannot reuse the verdict of the frame before
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ok_q <= 1'b0;
        end else if (frm_q != SRP_BUSY) begin
            ok_q <= 1'b0;
        end else if (!done_s && !long_s) begin
            ok_q <= 1'b1;
        end
    end

    // accept at release after exactly forty bits
    assign commit = (frm_q == SRP_BUSY) && cs_n_s && ok_q && done_s && !long_s;
    assign bad = (frm_q == SRP_BUSY) && cs_n_s && !(ok_q && done_s && !long_s);
    // split the frame into direction, address and data
    assign wr = frame[`SRP_WR_BIT];
    assign addr = f_addr(frame);
    assign wdata = f_data(frame);
    assign ev_clr = commit && !wr && (addr == `SRP_A_EVENT);
    assign err_clr = commit && wr && (addr == `SRP_A_ERRCNT);

    // read value multiplexer, narrow values right aligned
    always_comb begin
        rdata = '0;
        unique case (addr)
            `SRP_A_CFG: rdata = cfg_q;
            `SRP_A_EVENT: rdata = {{(`SRP_DATA_W-`SRP_EV_W){1'b0}}, ev_q};
            `SRP_A_MASK: rdata = {{(`SRP_DATA_W-`SRP_EV_W){1'b0}}, mask_q};
            `SRP_A_ERRCNT: rdata = errcnt_q;
            `SRP_A_TBL_RD: rdata = {{(`SRP_DATA_W-`SRP_TBL_DW){1'b0}}, trd_q};
            `SRP_A_VERSION: rdata = VERSION;
            default: rdata = '0;  // unmapped or write-only reads as zero
        endcase
    end

    // reply word: echo of the address byte, then the 32-bit read value, zero for writes
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            resp_q <= '0;
        end else if (commit) begin
            if (wr) begin
                resp_q <= {frame[`SRP_WR_BIT:`SRP_HDR_LO], `SRP_DATA_W'(0)};
            end else begin
                resp_q <= {frame[`SRP_WR_BIT:`SRP_HDR_LO], rdata};
            end
        end
    end

    // configuration word, written only over the link
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cfg_q <= `SRP_CFG_RST;
            mask_q <= `SRP_MASK_RST;
        end else if (commit && wr) begin  // read data bits never stored
            if (addr == `SRP_A_CFG) begin
                cfg_q <= wdata;
            end
            if (addr == `SRP_A_MASK) begin
                mask_q <= wdata[`SRP_EV_W-1:0];
            end
        end
    end

    // sticky events, cleared by reading them; a new event wins
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ev_q <= '0;
        end else begin
            ev_q <= (ev_clr ? '0 : ev_q) | event_in;
        end
    end

    // rejected frame counter, cleared by a write to SRP_A_ERRCNT; a new error wins
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            errcnt_q <= '0;
        end else if (bad) begin
            errcnt_q <= (err_clr ? '0 : errcnt_q) + `SRP_DATA_W'(1);
        end else if (err_clr) begin
            errcnt_q <= '0;
        end
    end

    // table write port: index and value packed in the data word
    always_ff @(posedge ref_clk_in) begin
        if (commit && wr && (addr == `SRP_A_TBL_WR)) begin
            table_mem[wdata[`SRP_TBL_IDX_HI:`SRP_TBL_IDX_LO]] <= wdata[`SRP_TBL_VAL_HI:0];
        end
    end

    // table read port: writing sets the pointer, each read fetches and advances
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            tptr_q <= '0;
            trd_q <= '0;
        end else if (commit && (addr == `SRP_A_TBL_RD)) begin
            if (wr) begin
                tptr_q <= wdata[`SRP_TBL_AW-1:0];
            end else begin
                trd_q <= table_mem[tptr_q];  // returned by the next read
                tptr_q <= tptr_q + `SRP_TBL_AW'(1);
            end
        end
    end

    // sequencer lookup, valid only once the host has loaded the table
    always_ff @(posedge ref_clk_in) begin
        seq_q <= table_mem[seq_idx_in];
    end

    // open-drain interrupt: drive low while an unmasked event is pending
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ev_q & mask_q);
        end
    end

    assign irq_out_n = 1'b0;
    assign irq_oe_out = irq_q;
    assign cfg_out = cfg_q;
    assign seq_val_out = seq_q;

    // interrupt pin follows masked events one cycle later
    irq_follow_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        ##1 irq_oe_out == |($past(ev_q) & $past(mask_q)))
        else $error("interrupt drive does not follow masked events");

    // a pending event stays until read
    event_sticky_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (ev_q != '0 && !ev_clr) |=> ((ev_q & $past(ev_q)) == $past(ev_q)))
        else $error("event flag lost without a read");

    // read of events returns them and clears them
    event_clear_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (ev_clr && event_in == '0) |=> (ev_q == '0 && resp_q[`SRP_EV_W-1:0] == $past(ev_q)))
        else $error("event read did not return and clear");

    // each rejected frame adds one to the error count
    errcnt_count_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        bad |=> errcnt_q == $past(errcnt_q) + `SRP_DATA_W'(1))
        else $error("rejected frame not counted");

    // write to the error count clears it
    errcnt_clear_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (err_clr && !bad) |=> errcnt_q == '0)
        else $error("error count not cleared by write");

    // reads never alter the configuration
    read_ignore_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (commit && !wr) |=> $stable(cfg_q) && $stable(mask_q))
        else $error("read changed configuration");

    // configuration write stores the data word
    cfg_write_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (commit && wr && addr == `SRP_A_CFG) |=> cfg_out == $past(wdata))
        else $error("configuration write not stored");

    // table read returns the previous fetch
    table_pipe_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (commit && !wr && addr == `SRP_A_TBL_RD)
        |=> resp_q[`SRP_TBL_DW-1:0] == $past(trd_q) && tptr_q == $past(tptr_q) + 1'b1)
        else $error("table read not pipelined by one frame");

    // frames that are not exactly forty bits leave the reply and configuration unchanged
    bad_frame_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        bad |=> $stable(resp_q) && $stable(cfg_q))
        else $error("rejected frame took effect");

    // version read answers the address byte and value
    resp_align_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (commit && !wr && addr == `SRP_A_VERSION)
        |=> resp_q == {1'b0, `SRP_A_VERSION, VERSION})
        else $error("reply word misaligned");
endmodule

/* File: verification/srp_host_model.sv */
// srp_host_model: behavioural serial master framing datagrams towards the port
// assumes the port samples on rising serial clock and moves its reply after it
`timescale 1ns/10ps
module srp_host_model
    import srp_pkg::*;
(
    // serial pins towards the port
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    // half of the 125 ns link period
    localparam real HALF = 62.5;

    // idle: clock low, deselected after a short select at start
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b0;
        mosi_out = 1'b0;
        // gives the link counter a rising select edge to clear on
        #10 cs_n_out = 1'b1;
    end

    // one frame of nbits bits, msb first; clock stands still outside frames
    task automatic xfer(input srp_frame_t tx, input int nbits, output srp_frame_t rx);
        rx = '0;
        #17 cs_n_out = 1'b0;
        for (int k = 0; k < nbits; k++) begin
            mosi_out = (k < 40) ? tx[39 - k] : 1'b0;
            #(HALF / 2);
            // reply bit taken only while the port drives it
            if (k < 40) begin
                rx[39 - k] = miso_oe_in ? miso_in : 1'bx;
            end
            #(HALF / 2) sclk_out = 1'b1;
            #HALF sclk_out = 1'b0;
        end
        #HALF cs_n_out = 1'b1;
        mosi_out = ~mosi_out;  // released line shows no stale value
        #1000;  // idle gap so commit and reply update land
    endtask
endmodule

/* File: verification/srp_top_bench.sv */
// srp_top_bench: self-checking bench of the serial register and table port
// assumes srp_host_model as the serial master and a 10 MHz core clock
`timescale 1ns/10ps
`include "srp_cfg.svh"
module srp_top_bench
    import srp_pkg::*;
;
    logic ref_clk = 1'b0;  // core clock
    logic srst = 1'b1;  // core reset
    logic sclk, cs_n, mosi, miso, miso_oe;  // serial pins
    logic irq_n, irq_oe;  // interrupt pin
    logic [`SRP_EV_W-1:0] ev = '0;  // event inputs
    srp_word_t cfg;  // configuration output
    srp_tidx_t seq_idx = '0;  // sequencer index
    srp_tval_t seq_val;  // sequencer value
    srp_frame_t rx;  // last reply
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // core clock, 100 ns
    always #50 ref_clk = ~ref_clk;

    srp_top i_srp_top (
        .ref_clk_in(ref_clk), .srst_in(srst),
        .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
        .irq_out_n(irq_n), .irq_oe_out(irq_oe),
        .event_in(ev), .cfg_out(cfg), .seq_idx_in(seq_idx), .seq_val_out(seq_val)
    );

    srp_host_model i_srp_host_model (
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
        .miso_in(miso), .miso_oe_in(miso_oe)
    );

    // verdict and end of run
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            $display("mismatch timeout expected done seen hang");
            stop_test();
        end
    end

    // one comparison
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // frame helpers; results read away from clock edges
    task automatic frame(input srp_frame_t tx, input int n);
        i_srp_host_model.xfer(tx, n, rx);
        @(negedge ref_clk);
    endtask

    task automatic wr(input srp_addr_t a, input srp_word_t d);
        frame({1'b1, a, d}, 40);
    endtask

    task automatic rd(input srp_addr_t a);
        frame({1'b0, a, 32'h0000_0000}, 40);
    endtask

    // event pulse of one core cycle, then settle
    task automatic pulse(input logic [`SRP_EV_W-1:0] v);
        @(posedge ref_clk) ev <= v;
        @(posedge ref_clk) ev <= '0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // reset values
    task automatic t_reset();
        chk("cfg reset", 40'h0, {8'h00, cfg});
        chk("irq idle", 40'h0, {39'h0, irq_oe});
        chk("irq level", 40'h0, {39'h0, irq_n});
    endtask

    // write, junk-data read, read back
    task automatic t_cfg();
        wr(`SRP_A_CFG, 32'h1234_5678);
        chk("cfg write", {8'h00, 32'h1234_5678}, {8'h00, cfg});
        frame({8'h00, 32'hffff_ffff}, 40);
        chk("cfg after read", {8'h00, 32'h1234_5678}, {8'h00, cfg});
        rd(7'h01);
        chk("cfg reply", {8'h00, 32'h1234_5678}, rx);
    endtask

    // table load, sequencer view, pipelined read back
    task automatic t_table();
        wr(`SRP_A_TBL_WR, {3'h0, 13'h0000, 4'h0, 12'habc});
        wr(`SRP_A_TBL_WR, {3'h0, 13'h0001, 4'h0, 12'h555});
        wr(`SRP_A_TBL_WR, {3'h0, 13'h1fff, 4'h0, 12'h123});
        @(posedge ref_clk) seq_idx <= 13'h1fff;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("table top entry", 40'h123, {28'h0, seq_val});
        wr(`SRP_A_TBL_RD, 32'h0000_0000);
        rd(`SRP_A_TBL_RD);
        rd(`SRP_A_TBL_RD);
        rd(`SRP_A_TBL_RD);
        chk("table read 0", {8'h06, 32'h0000_0abc}, rx);
        rd(7'h01);
        chk("table read 1", {8'h06, 32'h0000_0555}, rx);
    endtask

    // masked and unmasked events, clear on read
    task automatic t_irq();
        wr(`SRP_A_MASK, 32'h0000_0001);
        pulse(8'h02);
        chk("masked event", 40'h0, {39'h0, irq_oe});
        pulse(8'h01);
        chk("unmasked event", 40'h1, {39'h0, irq_oe});
        rd(`SRP_A_EVENT);
        rd(`SRP_A_EVENT);
        chk("event flags", {8'h02, 32'h0000_0003}, rx);
        rd(7'h01);
        chk("event cleared", {8'h02, 32'h0000_0000}, rx);
        chk("irq released", 40'h0, {39'h0, irq_oe});
    endtask

    // short and long frames, error count and its clear
    task automatic t_err();
        frame({1'b1, `SRP_A_CFG, 32'hdead_beef}, 39);
        frame({1'b1, `SRP_A_CFG, 32'hdead_beef}, 41);
        chk("cfg kept", {8'h00, 32'h1234_5678}, {8'h00, cfg});
        rd(`SRP_A_ERRCNT);
        rd(7'h01);
        chk("error count", {8'h04, 32'h0000_0002}, rx);
        wr(`SRP_A_ERRCNT, 32'h0000_00ff);
        rd(`SRP_A_ERRCNT);
        rd(7'h01);
        chk("error cleared", {8'h04, 32'h0000_0000}, rx);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        t_reset();
        t_cfg();
        t_table();
        t_irq();
        t_err();
        stop_test();
    end
endmodule
